// ---- logic/lir_defs.vh ----
`ifndef LIR_DEFS_VH
`define LIR_DEFS_VH
// source indices
`define LIR_SRC_TEST    4'h0
`define LIR_SRC_SCC1    4'h1
`define LIR_SRC_SCC2    4'h2
`define LIR_SRC_TMR1    4'h3
`define LIR_SRC_TMR2    4'h4
`define LIR_SRC_RTC     4'h5
`define LIR_SRC_SBIRQ   4'h6
`define LIR_SRC_ACFAIL  4'h7
`define LIR_SRC_SYSFAIL 4'h8
`define LIR_NSRC        9
// register offsets (word index on the plain port)
`define LIR_OFF_CTL0    6'h00
`define LIR_OFF_VEC0    6'h10
`define LIR_OFF_LVLEN   6'h20
`define LIR_OFF_STAT    6'h21
`define LIR_OFF_PEND    6'h22
`define LIR_OFF_T1CTL   6'h24
`define LIR_OFF_T1RLD   6'h25
`define LIR_OFF_T1CNT   6'h26
`define LIR_OFF_T2CTL   6'h28
`define LIR_OFF_T2RLD   6'h29
`define LIR_OFF_T2CNT   6'h2A
// control register fields
`define LIR_CTL_LVL_LSB 0
`define LIR_CTL_LVL_MSB 2
`define LIR_CTL_EN      3
// timer control fields
`define LIR_TCTL_RUN    5
`define LIR_TCTL_PS_MSB 4
// reset values
`define LIR_VEC_RST     8'h0F
`define LIR_LVLEN_RST   7'h00
// widths
`define LIR_TMR_W       24
`define LIR_PS_W        5
`endif

// ---- logic/lir_timer.v ----
`timescale 1ns/1ns
`include "lir_defs.vh"
// 24-bit down counter behind a 5-bit prescaler; pulses on wrap
module lir_timer (
  // clock and reset
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        ce_i,
  // control
  input  wire        run_i,
  input  wire [4:0]  ps_i,
  input  wire [23:0] reload_i,
  input  wire        load_i,
  // state
  output reg  [23:0] count_o,
  output reg         tick_o
);
  reg [4:0] ps_q;  // prescale counter

  ////////////////////////////////////////////////////////////////////
  // prescaler then counter; reload on zero so the period is reload+1
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      ps_q    <= 5'h00;
      count_o <= 24'h000000;
      tick_o  <= 1'b0;
    end else if (ce_i) begin
      tick_o <= 1'b0;
      if (load_i) begin
        ps_q    <= 5'h00;
        count_o <= reload_i;
      end else if (run_i) begin
        if (ps_q >= ps_i) begin
          ps_q <= 5'h00;
          if (count_o == 24'h000000) begin
            count_o <= reload_i;
            tick_o  <= 1'b1;  // [R5]
          end else begin
            count_o <= count_o - 24'h000001;
          end
        end else begin
          ps_q <= ps_q + 5'h01;
        end
      end
    end
  end
endmodule

// ---- logic/lir_router.v ----
`timescale 1ns/1ns
`include "lir_defs.vh"
// Operation
// (R1) nine local sources, two interrupter halves
// (R2) software picks request level per source
// (R3) programmable vector returned on acknowledge
// (R4) per-level enable masks all sources there
// (R5) two 24-bit timers with 5-bit prescaler
// (R6) timer vectors live in interrupter registers
// (R7) fail lines readable, optionally interrupting
// (R8) clock interrupt on level one to seven
// (R9) serial controllers own level and vector
// (R10) highest pending enabled level presented
module lir_router (
  // clock and reset
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire        ce_i,
  // register port
  input  wire [5:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  // external source pins, active high, taken on the rising edge
  input  wire        test_sw_i,
  input  wire        scc1_irq_i,
  input  wire        scc2_irq_i,
  input  wire        rtc_irq_i,
  input  wire        secondary_bus_irq_i,
  input  wire        acfail_i,
  input  wire        sysfail_i,
  // processor side
  output reg  [2:0]  ipl_o,
  input  wire        iack_i,
  input  wire [2:0]  iack_lvl_i,
  output reg  [7:0]  vec_o,
  output reg         vec_vld_o
);
  integer            k;                      // reset loop index
  integer            c;                      // combinational loop index
  reg  [7:0]         vec_q [0:`LIR_NSRC-1];  // vector per source
  reg  [3:0]         ctl_q [0:`LIR_NSRC-1];  // enable and level per source
  reg  [6:0]         lvlen_q;                // per-level enable
  reg  [8:0]         pend_q;                 // sticky pending per source
  wire [6:0]         sync1;                  // synchronised pins
  wire [6:0]         prev;                   // synchronised pins one cycle older
  wire [6:0]         edges;                  // rising edges of the pins
  reg                t1ld_q;                 // reload strobe, a cycle after the write
  reg                t2ld_q;                 // same for the second timer
  reg  [5:0]         t1ctl_q;
  reg  [5:0]         t2ctl_q;
  reg  [23:0]        t1rld_q;
  reg  [23:0]        t2rld_q;
  wire [23:0]        t1cnt;
  wire [23:0]        t2cnt;
  wire               t1tick;
  wire               t2tick;
  wire [6:0]         pins;
  wire [8:0]         events;
  reg  [6:0]         lvl_req;
  reg  [2:0]         top_lvl;
  reg  [3:0]         ack_src;
  reg                ack_hit;
  reg  [8:0]         pend_clr;               // pending bits cleared this cycle

  // the source whose level equals lvl and sits on the lowest index
  function [4:0] pick_src;
    input [2:0] lvl;
    input [8:0] pend;
    integer     j;
    begin
      pick_src = 5'h00;
      for (j = `LIR_NSRC - 1; j >= 0; j = j - 1) begin
        if (pend[j] && ctl_q[j][`LIR_CTL_EN] && ctl_q[j][2:0] == lvl) begin
          pick_src = {1'b1, j[3:0]};
        end
      end
    end
  endfunction

  assign pins = {sysfail_i, acfail_i, secondary_bus_irq_i, rtc_irq_i,
                 scc2_irq_i, scc1_irq_i, test_sw_i};

  ////////////////////////////////////////////////////////////////////
  // pins cross in through two flops; stage one feeds only stage two
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_sync
      reg s0_q;  // stage one, read by stage two only
      reg s1_q;  // stage two, the synchronised level
      reg p_q;   // stage two one cycle older, for the edge detect
      // reset low matches the idle pin level, so no false edge follows reset
      always @(posedge clk_i) begin
        if (!resetn_i) begin
          s0_q <= 1'b0;
          s1_q <= 1'b0;
          p_q  <= 1'b0;
        end else if (ce_i) begin
          s0_q <= pins[g];
          s1_q <= s0_q;
          p_q  <= s1_q;
        end
      end
      assign sync1[g] = s1_q;
      assign prev[g]  = p_q;
    end
  endgenerate

  // rising edges of pins plus timer wraps make the nine events [R1]
  assign edges  = sync1 & ~prev;
  assign events = {edges[6:3], t2tick, t1tick, edges[2:0]};

  ////////////////////////////////////////////////////////////////////
  // two timers
  lir_timer u_tmr1 (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .run_i    (t1ctl_q[`LIR_TCTL_RUN]),
    .ps_i     (t1ctl_q[`LIR_TCTL_PS_MSB:0]),
    .reload_i (t1rld_q),
    .load_i   (t1ld_q),
    .count_o  (t1cnt),
    .tick_o   (t1tick)
  );  // [R5]

  lir_timer u_tmr2 (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .run_i    (t2ctl_q[`LIR_TCTL_RUN]),
    .ps_i     (t2ctl_q[`LIR_TCTL_PS_MSB:0]),
    .reload_i (t2rld_q),
    .load_i   (t2ld_q),
    .count_o  (t2cnt),
    .tick_o   (t2tick)
  );

  ////////////////////////////////////////////////////////////////////
  // level gather, highest enabled level wins
  always @* begin
    lvl_req = 7'h00;
    for (c = 0; c < `LIR_NSRC; c = c + 1) begin
      if (pend_q[c] && ctl_q[c][`LIR_CTL_EN] && ctl_q[c][2:0] != 3'h0) begin
        lvl_req[ctl_q[c][2:0] - 3'h1] = 1'b1;  // [R2] [R8]
      end
    end
    lvl_req = lvl_req & lvlen_q;  // disabled level blocks all its sources [R4]
    top_lvl = 3'h0;
    for (c = 0; c < 7; c = c + 1) begin
      if (lvl_req[c]) begin
        top_lvl = c[2:0] + 3'h1;  // [R10]
      end
    end
    {ack_hit, ack_src} = pick_src(iack_lvl_i, pend_q);
    // a software clear and an acknowledge in one cycle must both take effect
    pend_clr = 9'h000;
    if (wr_i && addr_i == `LIR_OFF_PEND) begin
      pend_clr = wdata_i[8:0];
    end
    if (iack_i && ack_hit) begin
      pend_clr[ack_src] = 1'b1;  // acknowledged source leaves pending [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers, pending flags, acknowledge
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      for (k = 0; k < `LIR_NSRC; k = k + 1) begin
        vec_q[k] <= `LIR_VEC_RST;
        ctl_q[k] <= 4'h0;
      end
      lvlen_q   <= `LIR_LVLEN_RST;
      pend_q    <= 9'h000;
      t1ctl_q   <= 6'h00;
      t2ctl_q   <= 6'h00;
      t1rld_q   <= 24'h000000;
      t2rld_q   <= 24'h000000;
      t1ld_q    <= 1'b0;
      t2ld_q    <= 1'b0;
      ipl_o     <= 3'h0;
      vec_o     <= 8'h00;
      vec_vld_o <= 1'b0;
      rdata_o   <= 32'h00000000;
    end else if (ce_i) begin
      vec_vld_o <= 1'b0;
      ipl_o     <= top_lvl;
      // acknowledge hands out the picked source's vector; others stay pending
      if (iack_i && ack_hit) begin
        vec_o     <= vec_q[ack_src];  // [R3] [R6] [R9]
        vec_vld_o <= 1'b1;
      end
      // clears apply together; a new event beats any clear in the same cycle [R10]
      pend_q <= (pend_q & ~pend_clr) | events;
      // load a cycle after the reload write, so the timer takes the new value [R5]
      t1ld_q <= wr_i && addr_i == `LIR_OFF_T1RLD;
      t2ld_q <= wr_i && addr_i == `LIR_OFF_T2RLD;
      if (wr_i) begin
        if (addr_i < `LIR_OFF_CTL0 + 6'h09) begin
          ctl_q[addr_i[3:0]] <= wdata_i[3:0];  // [R2]
        end else if (addr_i >= `LIR_OFF_VEC0 && addr_i < `LIR_OFF_VEC0 + 6'h09) begin
          vec_q[addr_i[3:0]] <= wdata_i[7:0];  // [R3]
        end
        case (addr_i)
          `LIR_OFF_LVLEN: lvlen_q <= wdata_i[6:0];  // [R4]
          `LIR_OFF_T1CTL: t1ctl_q <= wdata_i[5:0];
          `LIR_OFF_T1RLD: t1rld_q <= wdata_i[23:0];
          `LIR_OFF_T2CTL: t2ctl_q <= wdata_i[5:0];
          `LIR_OFF_T2RLD: t2rld_q <= wdata_i[23:0];
          default: ;
        endcase
      end
      // read data stands one cycle after the strobe; unmapped reads zero
      rdata_o <= 32'h00000000;
      if (rd_i) begin
        if (addr_i < `LIR_OFF_CTL0 + 6'h09) begin
          rdata_o <= {28'h0000000, ctl_q[addr_i[3:0]]};
        end else if (addr_i >= `LIR_OFF_VEC0 && addr_i < `LIR_OFF_VEC0 + 6'h09) begin
          rdata_o <= {24'h000000, vec_q[addr_i[3:0]]};
        end else begin
          case (addr_i)
            `LIR_OFF_LVLEN: rdata_o <= {25'h0, lvlen_q};
            `LIR_OFF_STAT:  rdata_o <= {26'h0, top_lvl, 1'b0, sync1[6], sync1[5]};  // [R7]
            `LIR_OFF_PEND:  rdata_o <= {23'h0, pend_q};
            `LIR_OFF_T1CTL: rdata_o <= {26'h0, t1ctl_q};
            `LIR_OFF_T1RLD: rdata_o <= {8'h00, t1rld_q};
            `LIR_OFF_T1CNT: rdata_o <= {8'h00, t1cnt};
            `LIR_OFF_T2CTL: rdata_o <= {26'h0, t2ctl_q};
            `LIR_OFF_T2RLD: rdata_o <= {8'h00, t2rld_q};
            `LIR_OFF_T2CNT: rdata_o <= {8'h00, t2cnt};
            default:        rdata_o <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule

// ---- sim/lir_router_checker.sv ----
`timescale 1ns/1ns
`include "lir_defs.vh"
// watches the router ports; sees nothing inside
module lir_router_checker (
  // clock and reset
  input wire        clk_i,
  input wire        resetn_i,
  input wire        ce_i,
  // register port
  input wire        rd_i,
  input wire        wr_i,
  input wire [5:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire [31:0] rdata_o,
  // fail pins and processor side
  input wire        acfail_i,
  input wire        sysfail_i,
  input wire        iack_i,
  input wire [2:0]  iack_lvl_i,
  input wire [2:0]  ipl_o,
  input wire        vec_vld_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  rst_out_a: assert property (disable iff (1'b0) !resetn_i |=>
    ipl_o == 3'h0 && !vec_vld_o && rdata_o == 32'h0) else $error("reset left outputs set");
  rd_idle_a: assert property ($past(ce_i) && !$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data without read");
  unmapped_rd_a: assert property (ce_i && rd_i && addr_i == 6'h3F |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  // six quiet edges let the two sync stages settle before the read
  fail_stat_a: assert property (($stable({acfail_i, sysfail_i}) [*6]) ##0
    (ce_i && rd_i && addr_i == `LIR_OFF_STAT) |=> rdata_o[1:0] == $past({sysfail_i, acfail_i}))
    else $error("fail line state wrong");
  // status level and presented level are loaded from the same level on one edge
  stat_ipl_a: assert property (ce_i && rd_i && addr_i == `LIR_OFF_STAT |=>
    rdata_o[5:3] == ipl_o) else $error("status level wrong");
  // the presented level lags pending by a cycle, so skip just after a vector or a write
  ack_vec_a: assert property (ce_i && iack_i && !vec_vld_o && !wr_i && !$past(wr_i)
    && ipl_o != 3'h0 && iack_lvl_i == ipl_o |=> vec_vld_o) else $error("ack got no vector");
  vld_cause_a: assert property (vec_vld_o |-> $past(iack_i) && $past(ce_i))
    else $error("vector without ack");
  mask_all_a: assert property (ce_i && wr_i && addr_i == `LIR_OFF_LVLEN
    && wdata_i[6:0] == 7'h00 ##1 !wr_i |=> ipl_o == 3'h0) else $error("masked level shown");
  ce_freeze_a: assert property (!ce_i |=> $stable(ipl_o) && $stable(vec_vld_o)
    && $stable(rdata_o)) else $error("outputs moved while frozen");
  ack_c: cover property (iack_i ##1 vec_vld_o);
  top_lvl_c: cover property (ipl_o == 3'h7);
  stat_rd_c: cover property (rd_i && addr_i == `LIR_OFF_STAT);
endmodule
bind lir_router lir_router_checker u_lir_router_checker (
  .clk_i      (clk_i),
  .resetn_i   (resetn_i),
  .ce_i       (ce_i),
  .rd_i       (rd_i),
  .wr_i       (wr_i),
  .addr_i     (addr_i),
  .wdata_i    (wdata_i),
  .rdata_o    (rdata_o),
  .acfail_i   (acfail_i),
  .sysfail_i  (sysfail_i),
  .iack_i     (iack_i),
  .iack_lvl_i (iack_lvl_i),
  .ipl_o      (ipl_o),
  .vec_vld_o  (vec_vld_o)
);

// ---- sim/lir_cpu_model.sv ----
`timescale 1ns/1ns
// processor core: acks the presented level after delay_i cycles
module lir_cpu_model (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire       ack_en_i,
  input  wire [3:0] delay_i,
  input  wire [2:0] ipl_i,
  input  wire [7:0] vec_i,
  input  wire       vec_vld_i,
  output reg        iack_o,
  output reg  [2:0] iack_lvl_o,
  output reg  [2:0] lvl_o,
  output reg  [7:0] vec_o,
  output reg  [7:0] n_ack_o
);
  reg [3:0] wait_q;
  reg [1:0] cool_q;
  reg       busy_q;
  // cool-down: the level output trails the pending clear by one cycle
  always @(posedge clk_i) begin
    iack_o <= 1'b0;
    if (!resetn_i) begin
      {wait_q, cool_q, busy_q, n_ack_o, iack_lvl_o} <= 0;
    end else if (busy_q) begin
      if (vec_vld_i) begin
        busy_q <= 1'b0;
        cool_q <= 2'h2;
        vec_o <= vec_i;
        lvl_o <= iack_lvl_o;
        iack_lvl_o <= ~iack_lvl_o; // released lines show the complement of the acknowledged level
        n_ack_o <= n_ack_o + 8'h1;
      end
    end else if (cool_q != 2'h0) begin
      cool_q <= cool_q - 2'h1;
    end else if (ack_en_i && ipl_i != 3'h0) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q == delay_i) begin
        iack_o <= 1'b1;
        iack_lvl_o <= ipl_i;
        busy_q <= 1'b1;
        wait_q <= 4'h0;
      end
    end
  end
endmodule

// ---- sim/tb_lir_router.sv ----
`timescale 1ns/1ns
`include "lir_defs.vh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_lir_router;
  reg clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, ack_en = 1, ce_q = 1;
  reg [3:0] dly_q = 0;
  reg [5:0] addr_i = 0;
  reg [31:0] wdata_i = 0, d;
  reg [6:0] pin_q = 0;
  reg [7:0] n;
  wire [31:0] rdata_o;
  wire [7:0] vec_o, vec_seen, n_ack;
  wire [2:0] ipl_o, iack_lvl, lvl_seen;
  wire vec_vld_o, iack;
  integer n_errors = 0, comparisons = 0;
  logic [5:0] sidx [7] = '{6'h0, 6'h1, 6'h2, 6'h5, 6'h6, 6'h7, 6'h8};
  always #20 clk_i = ~clk_i;
  lir_router u_lir_router (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_q), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .test_sw_i(pin_q[0]),
    .scc1_irq_i(pin_q[1]), .scc2_irq_i(pin_q[2]), .rtc_irq_i(pin_q[3]),
    .secondary_bus_irq_i(pin_q[4]), .acfail_i(pin_q[5]), .sysfail_i(pin_q[6]),
    .ipl_o(ipl_o), .iack_i(iack), .iack_lvl_i(iack_lvl), .vec_o(vec_o), .vec_vld_o(vec_vld_o));
  lir_cpu_model u_lir_cpu_model (.clk_i(clk_i), .resetn_i(resetn_i), .ack_en_i(ack_en),
    .delay_i(dly_q), .ipl_i(ipl_o), .vec_i(vec_o), .vec_vld_i(vec_vld_o), .iack_o(iack),
    .iack_lvl_o(iack_lvl), .lvl_o(lvl_seen), .vec_o(vec_seen), .n_ack_o(n_ack));
  task wr(input [5:0] a, input [31:0] v);
    @(posedge clk_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input [5:0] a);
    @(posedge clk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    // read data stands in the cycle after the strobe; take it at the edge ending it
    @(posedge clk_i);
    d = rdata_o;
  endtask
  // bounded wait for the core model to finish ack number v
  task wack(input [7:0] v);
    for (int i = 0; i < 300 && n_ack !== v; i++) @(posedge clk_i);
    `CHK(n_ack, v)
  endtask
  task t_stat;
    rd(`LIR_OFF_VEC0);
    `CHK(d[7:0], `LIR_VEC_RST)
    rd(6'h3F);
    `CHK(d, 32'h00000000)
    pin_q <= 7'h20;
    repeat (6) @(posedge clk_i);
    rd(`LIR_OFF_STAT);
    `CHK(d[1:0], 2'b01)
    pin_q <= 7'h40;
    repeat (6) @(posedge clk_i);
    rd(`LIR_OFF_STAT);
    `CHK(d[1:0], 2'b10)
    pin_q <= 7'h00;
    wr(`LIR_OFF_PEND, 32'h1FF);
  endtask
  task t_mask;
    wr(`LIR_OFF_LVLEN, 32'h0);
    wr(`LIR_OFF_CTL0, 32'hB);
    wr(`LIR_OFF_LVLEN, 32'h7B);
    n = n_ack + 8'h1;
    pin_q[0] <= 1'b1;
    repeat (10) @(posedge clk_i);
    `CHK(ipl_o, 3'h0)
    wr(`LIR_OFF_LVLEN, 32'h7F);
    wack(n);
    `CHK(lvl_seen, 3'h3)
    pin_q[0] <= 1'b0;
  endtask
  // every pin source once, levels one to seven
  task t_route;
    for (bit [5:0] k = 0; k < 7; k++) begin
      wr(`LIR_OFF_VEC0 + sidx[k], 32'hA0 + sidx[k]);
      wr(sidx[k], 32'h9 + k);
      n = n_ack + 8'h1;
      pin_q[k] <= 1'b1;
      wack(n);
      `CHK(lvl_seen, k + 1)
      `CHK(vec_seen, 8'hA0 + sidx[k])
      pin_q[k] <= 1'b0;
      wr(sidx[k], 32'h0);
    end
  endtask
  task t_prio;
    ack_en <= 1'b0;
    dly_q <= 4'h3;
    wr(6'h1, 32'hA);
    wr(6'h2, 32'hE);
    n = n_ack + 8'h1;
    pin_q[2:1] <= 2'b11;
    repeat (8) @(posedge clk_i);
    `CHK(ipl_o, 3'h6)
    ack_en <= 1'b1;
    wack(n);
    `CHK(vec_seen, 8'hA2)
    wack(n + 8'h1);
    `CHK(vec_seen, 8'hA1)
    pin_q[2:1] <= 2'b00;
  endtask
  task t_timer;
    for (bit [5:0] t = 0; t < 2; t++) begin
      wr(`LIR_OFF_VEC0 + 6'h3 + t, 32'hC3 + t);
      wr(6'h3 + t, 32'hC + t);
      wr(`LIR_OFF_T1RLD + 6'h4 * t, 32'h3);
      rd(`LIR_OFF_T1CNT + 6'h4 * t);
      `CHK(d[23:0], 24'h000003)
      n = n_ack + 8'h1;
      wr(`LIR_OFF_T1CTL + 6'h4 * t, 32'h21);
      wack(n);
      `CHK(lvl_seen, 3'h4 + t)
      `CHK(vec_seen, 8'hC3 + t)
      wr(`LIR_OFF_T1CTL + 6'h4 * t, 32'h0);
      repeat (12) @(posedge clk_i);
    end
  endtask
  // a pin edge while the clock enable is low is only taken once it returns
  task t_ce;
    wr(`LIR_OFF_CTL0, 32'h9);
    n = n_ack;
    ce_q <= 1'b0;
    pin_q[0] <= 1'b1;
    repeat (10) @(posedge clk_i);
    `CHK(ipl_o, 3'h0)
    ce_q <= 1'b1;
    wack(n + 8'h1);
    `CHK(lvl_seen, 3'h1)
    pin_q[0] <= 1'b0;
  endtask
  // a second reset in mid-run brings enables and vectors back
  task t_rst;
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`LIR_OFF_LVLEN);
    `CHK(d[6:0], `LIR_LVLEN_RST)
    rd(`LIR_OFF_VEC0 + 6'h3);
    `CHK(d[7:0], `LIR_VEC_RST)
  endtask
  task test_done;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_stat; t_mask; t_route; t_prio; t_timer; t_ce; t_rst;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done;
  end
endmodule
